/* File: design/slpd_defines.vh */
// Operation
// - Empty flag per logical lane, read only
// - Full flag per logical lane, read only
// - Sync error at multiframe end after errors
// - Sync outputs low for programmed duration
// - Lane checker runs only when enabled
// - Source field selects reported lane count
// - Pattern field selects PRBS7, 15 or 31
// - Run bit starts and stops the test
// - Hold-reset bit clears checker and counters
// - 24-bit threshold from three bytes, reset zero
// - Selected lane count as three bytes
// - Pass bit while count below threshold
`ifndef SLPD_DEFINES_VH
`define SLPD_DEFINES_VH

`define SLPD_ADDR_W          12
`define SLPD_OFS_FIFO_FULL   12'h30C
`define SLPD_OFS_FIFO_EMPTY  12'h30D
`define SLPD_OFS_SYNC_CTRL   12'h312
`define SLPD_OFS_SERDES      12'h314
`define SLPD_OFS_BERT_EN     12'h315
`define SLPD_OFS_BERT_CTRL   12'h316
`define SLPD_OFS_THR_LO      12'h317
`define SLPD_OFS_THR_MID     12'h318
`define SLPD_OFS_THR_HI      12'h319
`define SLPD_OFS_CNT_LO      12'h31A
`define SLPD_OFS_CNT_MID     12'h31B
`define SLPD_OFS_CNT_HI      12'h31C
`define SLPD_OFS_PASS        12'h31D

`define SLPD_RST_ZERO        8'h00
`define SLPD_RST_PASS        8'hFF
`define SLPD_RST_SYNC_CTRL   8'h00

`define SLPD_SYNC_DUR_HI     5
`define SLPD_SYNC_DUR_LO     4
`define SLPD_CTRL_SRC_HI     6
`define SLPD_CTRL_SRC_LO     4
`define SLPD_CTRL_PAT_HI     3
`define SLPD_CTRL_PAT_LO     2
`define SLPD_CTRL_RUN        1
`define SLPD_CTRL_HOLD       0
`define SLPD_CTRL_WMASK      8'h7F

`define SLPD_DUR_HALF        2'h0
`define SLPD_DUR_ONE         2'h1
`define SLPD_LEN_HALF        3'h1
`define SLPD_LEN_ONE         3'h2
`define SLPD_LEN_TWO         3'h4

`define SLPD_PAT_7           2'h0
`define SLPD_PAT_15          2'h1
`define SLPD_PAT_31          2'h2
`define SLPD_TAP7_A          6
`define SLPD_TAP7_B          5
`define SLPD_TAP15_A         14
`define SLPD_TAP15_B         13
`define SLPD_TAP31_A         30
`define SLPD_TAP31_B         27

`define SLPD_HIST_W          31
`define SLPD_CNT_W           24
`define SLPD_CNT_MAX         24'hFFFFFF
`define SLPD_FILL_W          6
`define SLPD_FILL_FULL       6'h1F
`define SLPD_SYNC_IDLE       2'h3

`endif

/* File: design/slpd_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "slpd_defines.vh"

module slpd_top
#(
  parameter LANES     = 8,
  parameter LANE_BITS = 8
)
(
  input  wire                         ref_clk,
  input  wire                         srst,
  input  wire [`SLPD_ADDR_W-1:0]      reg_addr,
  input  wire [7:0]                   reg_wdata,
  input  wire                         reg_write,
  input  wire                         reg_read,
  output reg  [7:0]                   reg_rdata,
  input  wire [LANES-1:0]             lane_fifo_empty,
  input  wire [LANES-1:0]             lane_fifo_full,
  input  wire [LANES-1:0]             lane_disp_err,
  input  wire [LANES-1:0]             lane_nit_err,
  input  wire [LANES-1:0]             lane_unexp_ctrl_err,
  input  wire                         multiframe_end,
  input  wire [LANES*LANE_BITS-1:0]   serial_lane_input,
  input  wire [LANES-1:0]             serial_lane_valid,
  output reg  [1:0]                   link_sync_output_n,
  output reg  [7:0]                   serdes_setup_value
);

  reg  [7:0]              fifo_empty_q;
  reg  [7:0]              fifo_full_q;
  reg  [7:0]              sync_ctrl;
  reg  [7:0]              bert_en;
  reg  [7:0]              bert_ctrl;
  reg  [`SLPD_CNT_W-1:0]  bert_error_limit;
  reg                     mf_err_seen;
  reg  [2:0]              sync_left;
  reg  [2:0]              next_sync_len;
  reg  [`SLPD_CNT_W-1:0]  sel_tally;
  reg  [7:0]              next_rdata;

  wire [1:0]              sync_error_pulse_length;
  wire [2:0]              bert_count_lane_select;
  wire [1:0]              bert_pattern_select;
  wire                    bert_run;
  wire                    bert_hold_reset;
  wire [7:0]              lane_bert_enable_bits;
  wire [7:0]              bert_lane_ok_bits;
  wire                    any_char_err;
  wire [LANES*`SLPD_CNT_W-1:0] tally_flat;

  assign sync_error_pulse_length = sync_ctrl[`SLPD_SYNC_DUR_HI:`SLPD_SYNC_DUR_LO];
  assign bert_count_lane_select  = bert_ctrl[`SLPD_CTRL_SRC_HI:`SLPD_CTRL_SRC_LO];
  assign bert_pattern_select     = bert_ctrl[`SLPD_CTRL_PAT_HI:`SLPD_CTRL_PAT_LO];
  assign bert_run                = bert_ctrl[`SLPD_CTRL_RUN];
  assign bert_hold_reset         = bert_ctrl[`SLPD_CTRL_HOLD];
  assign lane_bert_enable_bits   = bert_en;
  assign any_char_err = |(lane_disp_err | lane_nit_err | lane_unexp_ctrl_err);

  // Feedback bit predicted from the received history
  function prbs_tap;
    input [`SLPD_HIST_W-1:0] h;
    input [1:0]              p;
    begin
      case (p)
        `SLPD_PAT_15: prbs_tap = h[`SLPD_TAP15_A] ^ h[`SLPD_TAP15_B];
        `SLPD_PAT_31: prbs_tap = h[`SLPD_TAP31_A] ^ h[`SLPD_TAP31_B];
        default:      prbs_tap = h[`SLPD_TAP7_A] ^ h[`SLPD_TAP7_B];
      endcase
    end
  endfunction

  // Count of mismatched bits in one word, oldest bit in bit 0
  function [7:0] prbs_errs;
    input [`SLPD_HIST_W-1:0] h;
    input [LANE_BITS-1:0]    d;
    input [1:0]              p;
    integer                  i;
    reg   [`SLPD_HIST_W-1:0] hh;
    begin
      hh        = h;
      prbs_errs = 8'h00;
      for (i = 0; i < LANE_BITS; i = i + 1)
      begin
        prbs_errs = prbs_errs + {7'h00, d[i] ^ prbs_tap(hh, p)};
        hh        = {hh[`SLPD_HIST_W-2:0], d[i]};
      end
    end
  endfunction

  // History after shifting in one word
  function [`SLPD_HIST_W-1:0] prbs_hist;
    input [`SLPD_HIST_W-1:0] h;
    input [LANE_BITS-1:0]    d;
    integer                  i;
    reg   [`SLPD_HIST_W-1:0] hh;
    begin
      hh = h;
      for (i = 0; i < LANE_BITS; i = i + 1)
      begin
        hh = {hh[`SLPD_HIST_W-2:0], d[i]};
      end
      prbs_hist = hh;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1)
    begin : lane
      reg  [`SLPD_HIST_W-1:0] hist;
      reg  [`SLPD_FILL_W-1:0] fill;
      reg  [`SLPD_CNT_W-1:0]  bert_error_tally;
      wire [LANE_BITS-1:0]    word;
      wire                    active;
      wire [7:0]              errs;
      wire [`SLPD_CNT_W:0]    sum;
      reg                     ok;

      assign word = serial_lane_input[g*LANE_BITS +: LANE_BITS];
      assign active = lane_bert_enable_bits[g] & bert_run & serial_lane_valid[g];
      assign errs = prbs_errs(hist, word, bert_pattern_select);
      assign sum  = {1'b0, bert_error_tally} + {{(`SLPD_CNT_W-7){1'b0}}, errs};
      assign tally_flat[g*`SLPD_CNT_W +: `SLPD_CNT_W] = bert_error_tally;
      assign bert_lane_ok_bits[g] = ok;

      always @(posedge ref_clk)
      begin
        if (srst || bert_hold_reset)
        begin
          hist             <= {`SLPD_HIST_W{1'b0}};
          fill             <= {`SLPD_FILL_W{1'b0}};
          bert_error_tally <= {`SLPD_CNT_W{1'b0}};
        end
        else if (active)
        begin
          hist <= prbs_hist(hist, word);
          // Self-synchronising check is blind until history is full
          if (fill < `SLPD_FILL_FULL)
          begin
            fill <= fill + LANE_BITS[`SLPD_FILL_W-1:0];
          end
          else if (sum[`SLPD_CNT_W])
          begin
            bert_error_tally <= `SLPD_CNT_MAX;
          end
          else
          begin
            bert_error_tally <= sum[`SLPD_CNT_W-1:0];
          end
        end
      end

      always @(posedge ref_clk)
      begin
        if (srst || bert_hold_reset)
        begin
          ok <= 1'b1;
        end
        else
        begin
          ok <= (bert_error_tally < bert_error_limit);
        end
      end
    end
  endgenerate

  always @*
  begin
    sel_tally = tally_flat[bert_count_lane_select*`SLPD_CNT_W +: `SLPD_CNT_W];
  end

  // Register writes, one process per register
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      sync_ctrl <= `SLPD_RST_SYNC_CTRL;
    end
    else if (reg_write && (reg_addr == `SLPD_OFS_SYNC_CTRL))
    begin
      sync_ctrl <= reg_wdata;
    end
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      serdes_setup_value <= `SLPD_RST_ZERO;
    end
    else if (reg_write && (reg_addr == `SLPD_OFS_SERDES))
    begin
      serdes_setup_value <= reg_wdata;
    end
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      bert_en <= `SLPD_RST_ZERO;
    end
    else if (reg_write && (reg_addr == `SLPD_OFS_BERT_EN))
    begin
      bert_en <= reg_wdata;
    end
  end

  // Reserved bit 7 is never stored
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      bert_ctrl <= `SLPD_RST_ZERO;
    end
    else if (reg_write && (reg_addr == `SLPD_OFS_BERT_CTRL))
    begin
      bert_ctrl <= reg_wdata & `SLPD_CTRL_WMASK;
    end
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      bert_error_limit <= {`SLPD_CNT_W{1'b0}};
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `SLPD_OFS_THR_LO:  bert_error_limit[7:0]   <= reg_wdata;
        `SLPD_OFS_THR_MID: bert_error_limit[15:8]  <= reg_wdata;
        `SLPD_OFS_THR_HI:  bert_error_limit[23:16] <= reg_wdata;
        default:           bert_error_limit        <= bert_error_limit;
      endcase
    end
  end

  // Flags are sampled so the read path sees a stable copy
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      fifo_empty_q <= `SLPD_RST_ZERO;
      fifo_full_q  <= `SLPD_RST_ZERO;
    end
    else
    begin
      fifo_empty_q <= lane_fifo_empty;
      fifo_full_q  <= lane_fifo_full;
    end
  end

  always @*
  begin
    case (reg_addr)
      `SLPD_OFS_FIFO_FULL:  next_rdata = fifo_full_q;
      `SLPD_OFS_FIFO_EMPTY: next_rdata = fifo_empty_q;
      `SLPD_OFS_SYNC_CTRL:  next_rdata = sync_ctrl;
      `SLPD_OFS_SERDES:     next_rdata = serdes_setup_value;
      `SLPD_OFS_BERT_EN:    next_rdata = bert_en;
      `SLPD_OFS_BERT_CTRL:  next_rdata = bert_ctrl;
      `SLPD_OFS_THR_LO:     next_rdata = bert_error_limit[7:0];
      `SLPD_OFS_THR_MID:    next_rdata = bert_error_limit[15:8];
      `SLPD_OFS_THR_HI:     next_rdata = bert_error_limit[23:16];
      `SLPD_OFS_CNT_LO:     next_rdata = sel_tally[7:0];
      `SLPD_OFS_CNT_MID:    next_rdata = sel_tally[15:8];
      `SLPD_OFS_CNT_HI:     next_rdata = sel_tally[23:16];
      `SLPD_OFS_PASS:       next_rdata = bert_lane_ok_bits;
      default:              next_rdata = `SLPD_RST_ZERO;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      reg_rdata <= `SLPD_RST_ZERO;
    end
    else if (reg_read)
    begin
      reg_rdata <= next_rdata;
    end
  end

  // Half a parallel clock is one ref_clk cycle; code 3 behaves as code 2
  always @*
  begin
    case (sync_error_pulse_length)
      `SLPD_DUR_HALF: next_sync_len = `SLPD_LEN_HALF;
      `SLPD_DUR_ONE:  next_sync_len = `SLPD_LEN_ONE;
      default:        next_sync_len = `SLPD_LEN_TWO;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      mf_err_seen        <= 1'b0;
      sync_left          <= 3'h0;
      link_sync_output_n <= `SLPD_SYNC_IDLE;
    end
    else
    begin
      // Errors in the closing cycle still count
      if (multiframe_end)
      begin
        mf_err_seen <= 1'b0;
      end
      else if (any_char_err)
      begin
        mf_err_seen <= 1'b1;
      end
      if (multiframe_end && (mf_err_seen || any_char_err))
      begin
        sync_left          <= next_sync_len - 3'h1;
        link_sync_output_n <= 2'h0;
      end
      else if (sync_left != 3'h0)
      begin
        sync_left <= sync_left - 3'h1;
      end
      else
      begin
        link_sync_output_n <= `SLPD_SYNC_IDLE;
      end
    end
  end

endmodule
`default_nettype wire

/* File: testbench/slpd_lane_src.sv */
`timescale 1ns/100ps
`default_nettype none

module slpd_lane_src
(
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [1:0]  pat,
  input  wire logic [7:0]  err,
  output var  logic [63:0] data,
  output var  logic [7:0]  valid
);
  logic [30:0] s = '1;
  logic [30:0] n;
  logic [7:0]  w;
  logic [63:0] e;

  // Idle lanes carry the inverse, so a stale word never looks valid
  always_comb
  begin
    n = s;
    e = '0;
    for (int i = 0; i < 8; i++)
    begin
      n = {n[29:0], pat[1] ? n[30] ^ n[27] : pat[0] ? n[14] ^ n[13] : n[6] ^ n[5]};
      w[i] = n[0];
      e[i*8] = err[i];
    end
    data  = go ? {8{w}} ^ e : ~{8{w}};
    valid = {8{go}};
  end

  always @(posedge clk)
    if (go)
      s <= n;
endmodule

`default_nettype wire

/* File: testbench/slpd_properties.sv */
`timescale 1ns/100ps
`default_nettype none
`include "slpd_defines.vh"

module slpd_properties
#(
  parameter LANES = 8
)
(
  input wire logic                    ref_clk,
  input wire logic                    srst,
  input wire logic [`SLPD_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_write,
  input wire logic                    reg_read,
  input wire logic [7:0]              reg_rdata,
  input wire logic [LANES-1:0]        lane_fifo_empty,
  input wire logic [LANES-1:0]        lane_disp_err,
  input wire logic [LANES-1:0]        lane_nit_err,
  input wire logic [LANES-1:0]        lane_unexp_ctrl_err,
  input wire logic                    multiframe_end,
  input wire logic [1:0]              link_sync_output_n,
  input wire logic [7:0]              serdes_setup_value
);
  logic       seen;
  logic [1:0] dur;
  logic [2:0] lowcnt;
  wire        any_err;

  assign any_err = |{lane_disp_err, lane_nit_err, lane_unexp_ctrl_err};

  // Mirrors the error accumulator, pulse length code and low run length
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      seen   <= 1'b0;
      dur    <= 2'h0;
      lowcnt <= 3'h0;
    end
    else
    begin
      seen   <= !multiframe_end && (seen || any_err);
      lowcnt <= (link_sync_output_n == 2'h0) ? lowcnt + 3'h1 : 3'h0;
      if (reg_write && reg_addr == `SLPD_OFS_SYNC_CTRL)
        dur <= reg_wdata[5:4];
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  a_rst_idle: assert property (
    $past(srst) |-> link_sync_output_n == 2'h3 && reg_rdata == 8'h00)
    else $error("outputs not idle after reset");
  a_sync_pair: assert property (
    link_sync_output_n[0] == link_sync_output_n[1])
    else $error("sync outputs differ");
  a_sync_fall: assert property (
    multiframe_end && (seen || any_err) |=> link_sync_output_n == 2'h0)
    else $error("sync error not raised");
  a_sync_cause: assert property (
    $fell(link_sync_output_n[0]) |-> $past(multiframe_end && (seen || any_err)))
    else $error("sync low without cause");
  a_sync_len: assert property (
    $rose(link_sync_output_n[0]) |-> lowcnt == (dur[1] ? 3'h4 : dur[0] ? 3'h2 : 3'h1))
    else $error("sync low length wrong");
  a_serdes_copy: assert property (
    reg_write && reg_addr == `SLPD_OFS_SERDES |=> serdes_setup_value == $past(reg_wdata))
    else $error("serdes byte not stored");
  a_rdata_hold: assert property (
    !reg_read |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_empty_read: assert property (
    reg_read && reg_addr == `SLPD_OFS_FIFO_EMPTY |=> reg_rdata == $past(lane_fifo_empty, 2))
    else $error("empty flags read wrong");
endmodule

bind slpd_top slpd_properties #(.LANES(LANES)) u_props (
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .lane_fifo_empty(lane_fifo_empty), .lane_disp_err(lane_disp_err),
  .lane_nit_err(lane_nit_err), .lane_unexp_ctrl_err(lane_unexp_ctrl_err),
  .multiframe_end(multiframe_end), .link_sync_output_n(link_sync_output_n),
  .serdes_setup_value(serdes_setup_value));

`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        ref_clk, srst, reg_write, reg_read, mfe, go;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, f_emp, f_full, e_dsp, e_nit, e_unx;
  logic [7:0]  serdes, valid, err, en, em, thr, r;
  logic [1:0]  link_n, pat;
  logic [63:0] lanes;
  integer      seed = 37, miscompares = 0, checks_done = 0, cyc = 0;

  slpd_top u_dut (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .lane_fifo_empty(f_emp), .lane_fifo_full(f_full), .lane_disp_err(e_dsp),
    .lane_nit_err(e_nit), .lane_unexp_ctrl_err(e_unx), .multiframe_end(mfe),
    .serial_lane_input(lanes), .serial_lane_valid(valid),
    .link_sync_output_n(link_n), .serdes_setup_value(serdes));
  slpd_lane_src u_src (
    .clk(ref_clk), .go(go), .pat(pat), .err(err), .data(lanes), .valid(valid));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      miscompares = miscompares + 1;
      test_done;
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checks_done = checks_done + 1;
    if (g !== x)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
      miscompares = miscompares + 1;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_addr  = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] x);
    @(negedge ref_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    chk(reg_rdata, x);
  endtask

  function automatic logic [7:0] rexp(input logic [11:0] a, input logic [7:0] v);
    case (a)
      12'h316: rexp = v & 8'h7F;
      12'h313, 12'h31A, 12'h31B, 12'h31C: rexp = 8'h00;
      12'h31D: rexp = 8'hFF;
      default: rexp = v;
    endcase
  endfunction

  // Window covers either landing edge of the low pulse
  task automatic sync_try(input logic hit, input logic [7:0] len);
    logic [7:0] lows;
    lows = 8'h00;
    {e_dsp, e_nit, e_unx} = hit ? 24'h1 << ({$random(seed)} % 24) : 24'h0;
    @(negedge ref_clk);
    {e_dsp, e_nit, e_unx} = 24'h0;
    repeat (3) @(negedge ref_clk);
    mfe = 1'b1;
    @(negedge ref_clk);
    mfe = 1'b0;
    repeat (9)
    begin
      lows = lows + {7'h00, link_n == 2'h0};
      @(negedge ref_clk);
    end
    chk(lows, len);
  endtask

  // Flips bit 0 every tenth word, with random stalls between words
  task automatic feed(input int nw, input logic [7:0] m);
    for (int i = 0; i < nw; i++)
    begin
      if ({$random(seed)} % 4 == 0)
      begin
        go = 1'b0;
        @(negedge ref_clk);
      end
      go  = 1'b1;
      err = (i % 10 == 5) ? m : 8'h00;
      @(negedge ref_clk);
    end
    go  = 1'b0;
    err = 8'h00;
  endtask

  initial
  begin
    {srst, reg_write, reg_read, mfe, go} = 5'h10;
    {reg_addr, reg_wdata, pat, err, f_emp, f_full, e_dsp, e_nit, e_unx} = 70'h0;
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    for (int a = 12'h312; a < 12'h31E; a++)
    begin
      r = 8'($random(seed));
      rc(a[11:0], a == 12'h31D ? 8'hFF : 8'h00);
      wr(a[11:0], r);
      rc(a[11:0], rexp(a[11:0], r));
    end
    wr(12'h314, 8'h01);
    chk(serdes, 8'h01);
    repeat (3)
    begin
      {f_emp, f_full} = 16'($random(seed));
      rc(12'h30D, f_emp);
      rc(12'h30C, f_full);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(12'h312, {2'h0, c[1:0], 4'h0});
      sync_try(1'b1, c == 0 ? 8'h01 : c == 1 ? 8'h02 : 8'h04);
      sync_try(1'b0, 8'h00);
    end
    // Each flipped bit upsets three checks: 4 flips give 12 errors
    for (int p = 0; p < 3; p++)
    begin
      pat = p[1:0];
      en  = 8'($random(seed)) | 8'h80;
      em  = 8'($random(seed)) | 8'h80;
      thr = 8'h0C + {7'h00, 1'($random(seed))};
      wr(12'h315, en);
      wr(12'h317, thr);
      wr(12'h318, 8'h00);
      wr(12'h319, 8'h00);
      wr(12'h316, {1'b0, 3'h7, pat, 2'h1});
      rc(12'h31A, 8'h00);
      wr(12'h316, {4'h0, pat, 2'h2});
      feed(40, em);
      wr(12'h316, {4'h0, pat, 2'h0});
      feed(20, 8'hFF);
      rc(12'h31D, thr == 8'h0D ? 8'hFF : ~(en & em));
      for (int g = 0; g < 8; g++)
      begin
        wr(12'h316, {1'b0, g[2:0], pat, 2'h0});
        rc(12'h31A, en[g] && em[g] ? 8'h0C : 8'h00);
        rc(12'h31B, 8'h00);
        rc(12'h31C, 8'h00);
      end
    end
    // A second reset must bring serdes, threshold, control and the count low byte back to zero
    srst = 1'b1;
    repeat (3) @(negedge ref_clk);
    srst = 1'b0;
    chk(serdes, 8'h00);
    rc(12'h317, 8'h00);
    rc(12'h318, 8'h00);
    rc(12'h319, 8'h00);
    rc(12'h316, 8'h00);
    rc(12'h31A, 8'h00);
    test_done;
  end
endmodule

`default_nettype wire
